/* core/sdr_pkg.sv */
// Shared constants and types for the shift and digit rotate unit
package sdr_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_BC = 8'h0C;
  localparam logic [7:0] OFF_DE = 8'h10;
  localparam logic [7:0] OFF_HL = 8'h14;
  localparam logic [7:0] OFF_AF = 8'h18;
  localparam logic [7:0] OFF_IDX1 = 8'h1C;
  localparam logic [7:0] OFF_IDX2 = 8'h20;
  localparam int CTRL_GO = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ERR = 1;
  localparam int STAT_MC_LSB = 8;
  localparam int STAT_TS_LSB = 16;
  localparam int FLG_S = 7;
  localparam int FLG_Z = 6;
  localparam int FLG_H = 4;
  localparam int FLG_PV = 2;
  localparam int FLG_N = 1;
  localparam int FLG_C = 0;
  localparam logic [7:0] PFX_CB = 8'hCB;
  localparam logic [7:0] PFX_IDX1 = 8'hDD;
  localparam logic [7:0] PFX_IDX2 = 8'hFD;
  localparam logic [7:0] PFX_ED = 8'hED;
  localparam logic [7:0] OP_DIGIT_LEFT = 8'h6F;
  localparam logic [4:0] GRP_SLA = 5'h04;
  localparam logic [4:0] GRP_SRA = 5'h05;
  localparam logic [4:0] GRP_SRL = 5'h07;
  localparam logic [2:0] SEL_H = 3'h4;
  localparam logic [2:0] SEL_L = 3'h5;
  localparam logic [2:0] SEL_MEM = 3'h6;
  localparam logic [2:0] SEL_A = 3'h7;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [15:0] RST_IDX = 16'h0000;
  localparam logic [31:0] RST_INSTR = 32'h0000_0000;
  // Machine cycle lengths in T states, first machine cycle in the low nibble
  localparam logic [23:0] MLEN_REG = 24'h000044;
  localparam logic [23:0] MLEN_PTR = 24'h003444;
  localparam logic [23:0] MLEN_IDX = 24'h345344;
  localparam logic [23:0] MLEN_DRL = 24'h034344;
  localparam logic [2:0] MC_REG = 3'h2;
  localparam logic [2:0] MC_PTR = 3'h4;
  localparam logic [2:0] MC_IDX = 3'h6;
  localparam logic [2:0] MC_DRL = 3'h5;
  localparam logic [2:0] RD_PTR = 3'h2;
  localparam logic [2:0] WR_PTR = 3'h3;
  localparam logic [2:0] RD_IDX = 3'h4;
  localparam logic [2:0] WR_IDX = 3'h5;
  localparam logic [2:0] RD_DRL = 3'h2;
  localparam logic [2:0] WR_DRL = 3'h4;
  localparam logic [2:0] MC_NONE = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [1:0] {OP_SLA, OP_SRA, OP_SRL, OP_DRL} sdr_op_e;
  typedef enum logic [1:0] {MD_REG, MD_PTR, MD_IDX, MD_DRL} sdr_mode_e;
endpackage

/* core/sdr_alu.sv */
// Combinational shift and digit rotate datapath with flag generation
`timescale 1ns/1ps
module sdr_alu import sdr_pkg::*; (
  input wire sdr_op_e op_in,
  input wire logic [7:0] opnd_in,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] flags_in,
  output logic [7:0] result_out,
  output logic [7:0] acc_out,
  output logic [7:0] flags_out
);
  logic [7:0] flag_src;
  logic carry;

  always_comb begin
    result_out = opnd_in;
    acc_out = acc_in;
    carry = flags_in[FLG_C];
    case (op_in)
      OP_SLA: begin
        result_out = {opnd_in[6:0], 1'b0};
        carry = opnd_in[7];
      end
      OP_SRA: begin
        result_out = {opnd_in[7], opnd_in[7:1]};
        carry = opnd_in[0];
      end
      OP_SRL: begin
        result_out = {1'b0, opnd_in[7:1]};
        carry = opnd_in[0];
      end
      OP_DRL: begin
        result_out = {opnd_in[3:0], acc_in[3:0]};
        acc_out = {acc_in[7:4], opnd_in[7:4]};
      end
      default: begin
        result_out = opnd_in;
      end
    endcase
    flag_src = (op_in == OP_DRL) ? acc_out : result_out;
    // Undocumented bits 5 and 3 keep their old value
    flags_out = flags_in;
    flags_out[FLG_S] = (op_in == OP_SRL) ? 1'b0 : flag_src[7];
    flags_out[FLG_Z] = (flag_src == 8'h00);
    flags_out[FLG_H] = 1'b0;
    flags_out[FLG_PV] = ~^flag_src;
    flags_out[FLG_N] = 1'b0;
    flags_out[FLG_C] = carry;
  end
endmodule // sdr_alu

/* core/sdr_axil.sv */
// AXI4-Lite slave front end: channel handshakes and response timing
`timescale 1ns/1ps
module sdr_axil import sdr_pkg::*; #(
  parameter int AW = ADDR_W
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [AW-1:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  output logic wr_en_out,
  output logic [AW-1:0] wr_addr_out,
  output logic [31:0] wr_data_out,
  output logic [3:0] wr_strb_out,
  input wire logic [1:0] wr_resp_in,
  input wire logic [31:0] rd_data_in,
  input wire logic [1:0] rd_resp_in
);
  // Both halves held and no response pending: commit the write now
  assign wr_en_out = !awready_out && !wready_out && !bvalid_out;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      awready_out <= 1'b1;
      wr_addr_out <= '0;
    end else if (awvalid_in && awready_out) begin
      awready_out <= 1'b0;
      wr_addr_out <= awaddr_in;
    end else if (bvalid_out && bready_in) begin
      awready_out <= 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wready_out <= 1'b1;
      wr_data_out <= 32'h0000_0000;
      wr_strb_out <= 4'h0;
    end else if (wvalid_in && wready_out) begin
      wready_out <= 1'b0;
      wr_data_out <= wdata_in;
      wr_strb_out <= wstrb_in;
    end else if (bvalid_out && bready_in) begin
      wready_out <= 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bvalid_out <= 1'b0;
      bresp_out <= RESP_OKAY;
    end else if (wr_en_out) begin
      bvalid_out <= 1'b1;
      bresp_out <= wr_resp_in;
    end else if (bready_in) begin
      bvalid_out <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      arready_out <= 1'b1;
      rvalid_out <= 1'b0;
      rdata_out <= 32'h0000_0000;
      rresp_out <= RESP_OKAY;
    end else if (arvalid_in && arready_out) begin
      arready_out <= 1'b0;
      rvalid_out <= 1'b1;
      rdata_out <= rd_data_in;
      rresp_out <= rd_resp_in;
    end else if (rvalid_out && rready_in) begin
      arready_out <= 1'b1;
      rvalid_out <= 1'b0;
    end
  end
endmodule // sdr_axil

/* core/sdr_unit.sv */
// Shift and digit rotate unit: decoder, cycle sequencer, registers, bus port
//
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
module sdr_unit import sdr_pkg::*; (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [15:0] mem_addr_out,
  output logic mem_rd_out,
  output logic mem_wr_out,
  output logic [7:0] mem_wdata_out,
  input wire logic [7:0] mem_rdata_in,
  output logic busy_out
);
  typedef enum logic {ST_IDLE, ST_RUN} sdr_state_e;

  // Slot 6 of the file holds the flags: selector 110 always means memory
  logic [7:0] gpr [8];
  logic [15:0] idx1, idx2, dec_addr;
  logic [31:0] instr, wr_data, rd_data;
  logic err, last_t, commit, dec_ok, wr_en, wr_ok, go;
  logic [2:0] last_mc, sel, mc, ts, next_mc, next_ts;
  logic [4:0] last_ts, tcount;
  sdr_state_e state, next_state;
  sdr_mode_e mode, dec_mode;
  sdr_op_e op, dec_op;
  logic [7:0] opnd, dec_code, alu_result, alu_acc, alu_flags;
  logic [ADDR_W-1:0] wr_addr;
  logic [3:0] wr_strb;
  logic [1:0] wr_resp, rd_resp;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    reg_hit = (a == OFF_INSTR) || (a == OFF_CTRL) || (a == OFF_STATUS) || (a == OFF_BC) ||
      (a == OFF_DE) || (a == OFF_HL) || (a == OFF_AF) || (a == OFF_IDX1) || (a == OFF_IDX2);
  endfunction
  function automatic logic shift_ok(input logic [7:0] code);
    shift_ok = (code[7:3] == GRP_SLA) || (code[7:3] == GRP_SRA) || (code[7:3] == GRP_SRL);
  endfunction
  function automatic sdr_op_e shift_op(input logic [7:0] code);
    case (code[7:3])
      GRP_SRA: shift_op = OP_SRA;
      GRP_SRL: shift_op = OP_SRL;
      default: shift_op = OP_SLA;
    endcase
  endfunction
  function automatic logic [3:0] mlen(input sdr_mode_e m, input logic [2:0] i);
    logic [23:0] t;
    case (m)
      MD_PTR: t = MLEN_PTR;
      MD_IDX: t = MLEN_IDX;
      MD_DRL: t = MLEN_DRL;
      default: t = MLEN_REG;
    endcase
    mlen = t[i*4 +: 4];
  endfunction
  function automatic logic [2:0] mcount(input sdr_mode_e m);
    case (m)
      MD_PTR: mcount = MC_PTR;
      MD_IDX: mcount = MC_IDX;
      MD_DRL: mcount = MC_DRL;
      default: mcount = MC_REG;
    endcase
  endfunction
  function automatic logic [2:0] rd_cycle(input sdr_mode_e m);
    case (m)
      MD_PTR: rd_cycle = RD_PTR;
      MD_IDX: rd_cycle = RD_IDX;
      MD_DRL: rd_cycle = RD_DRL;
      default: rd_cycle = MC_NONE;
    endcase
  endfunction
  function automatic logic [2:0] wr_cycle(input sdr_mode_e m);
    case (m)
      MD_PTR: wr_cycle = WR_PTR;
      MD_IDX: wr_cycle = WR_IDX;
      MD_DRL: wr_cycle = WR_DRL;
      default: wr_cycle = MC_NONE;
    endcase
  endfunction

  sdr_axil #(
    .AW(ADDR_W)
  ) u_axil (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .awaddr_in(s_axi_awaddr_in),
    .awvalid_in(s_axi_awvalid_in),
    .awready_out(s_axi_awready_out),
    .wdata_in(s_axi_wdata_in),
    .wstrb_in(s_axi_wstrb_in),
    .wvalid_in(s_axi_wvalid_in),
    .wready_out(s_axi_wready_out),
    .bresp_out(s_axi_bresp_out),
    .bvalid_out(s_axi_bvalid_out),
    .bready_in(s_axi_bready_in),
    .arvalid_in(s_axi_arvalid_in),
    .arready_out(s_axi_arready_out),
    .rdata_out(s_axi_rdata_out),
    .rresp_out(s_axi_rresp_out),
    .rvalid_out(s_axi_rvalid_out),
    .rready_in(s_axi_rready_in),
    .wr_en_out(wr_en),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data),
    .wr_strb_out(wr_strb),
    .wr_resp_in(wr_resp),
    .rd_data_in(rd_data),
    .rd_resp_in(rd_resp)
  );

  sdr_alu u_alu (
    .op_in(op),
    .opnd_in(opnd),
    .acc_in(gpr[SEL_A]),
    .flags_in(gpr[SEL_MEM]),
    .result_out(alu_result),
    .acc_out(alu_acc),
    .flags_out(alu_flags)
  );

  // Operand state may not change under a running instruction
  always_comb begin
    if (!reg_hit(wr_addr)) begin
      wr_resp = RESP_DECERR;
    end else if (state == ST_RUN && wr_addr != OFF_CTRL && wr_addr != OFF_STATUS) begin
      wr_resp = RESP_SLVERR;
    end else begin
      wr_resp = RESP_OKAY;
    end
  end
  assign wr_ok = wr_en && (wr_resp == RESP_OKAY);
  assign go = wr_ok && (wr_addr == OFF_CTRL) && wr_strb[0] && wr_data[CTRL_GO];

  always_comb begin
    rd_resp = reg_hit(s_axi_araddr_in) ? RESP_OKAY : RESP_DECERR;
    case (s_axi_araddr_in)
      OFF_INSTR: rd_data = instr;
      OFF_STATUS: rd_data = {11'h000, last_ts, 5'h00, last_mc, 6'h00, err, busy_out};
      OFF_BC: rd_data = {16'h0000, gpr[0], gpr[1]};
      OFF_DE: rd_data = {16'h0000, gpr[2], gpr[3]};
      OFF_HL: rd_data = {16'h0000, gpr[SEL_H], gpr[SEL_L]};
      OFF_AF: rd_data = {16'h0000, gpr[SEL_A], gpr[SEL_MEM]};
      OFF_IDX1: rd_data = {16'h0000, idx1};
      OFF_IDX2: rd_data = {16'h0000, idx2};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Instruction decode from the byte image
  always_comb begin
    dec_ok = 1'b0;
    dec_mode = MD_REG;
    dec_code = instr[15:8];
    if (instr[7:0] == PFX_CB) begin
      dec_ok = shift_ok(dec_code);
      dec_mode = (dec_code[2:0] == SEL_MEM) ? MD_PTR : MD_REG;
    end else if ((instr[7:0] == PFX_IDX1 || instr[7:0] == PFX_IDX2) && instr[15:8] == PFX_CB) begin
      dec_code = instr[31:24];
      dec_ok = shift_ok(dec_code) && (dec_code[2:0] == SEL_MEM);
      dec_mode = MD_IDX;
    end else if (instr[7:0] == PFX_ED && instr[15:8] == OP_DIGIT_LEFT) begin
      dec_ok = 1'b1;
      dec_mode = MD_DRL;
    end
    dec_op = (dec_mode == MD_DRL) ? OP_DRL : shift_op(dec_code);
    case (dec_mode)
      MD_IDX: dec_addr = ((instr[7:0] == PFX_IDX1) ? idx1 : idx2) + {{8{instr[23]}}, instr[23:16]};
      default: dec_addr = {gpr[SEL_H], gpr[SEL_L]};
    endcase
  end

  // Machine cycle and T state sequencing
  assign last_t = ({1'b0, ts} == mlen(mode, mc)) && (mc == mcount(mode) - 3'h1);
  assign commit = (state == ST_RUN) && last_t;

  always_comb begin
    next_state = state;
    next_mc = mc;
    next_ts = ts + 3'h1;
    if (state == ST_IDLE) begin
      next_mc = 3'h0;
      next_ts = 3'h1;
      if (go && dec_ok) begin
        next_state = ST_RUN;
      end
    end else if ({1'b0, ts} == mlen(mode, mc)) begin
      next_ts = 3'h1;
      next_mc = mc + 3'h1;
      if (last_t) begin
        next_state = ST_IDLE;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= ST_IDLE;
      mc <= 3'h0;
      ts <= 3'h1;
      busy_out <= 1'b0;
    end else begin
      state <= next_state;
      mc <= next_mc;
      ts <= next_ts;
      busy_out <= (next_state == ST_RUN);
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tcount <= 5'h00;
      last_ts <= 5'h00;
      last_mc <= 3'h0;
    end else if (state == ST_IDLE) begin
      tcount <= 5'h01;
    end else begin
      tcount <= tcount + 5'h01;
      if (commit) begin
        last_ts <= tcount;
        last_mc <= mc + 3'h1;
      end
    end
  end

  // Instruction latched at start so register writes cannot disturb it
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode <= MD_REG;
      op <= OP_SLA;
      sel <= 3'h0;
      mem_addr_out <= 16'h0000;
    end else if (state == ST_IDLE && go && dec_ok) begin
      mode <= dec_mode;
      op <= dec_op;
      sel <= dec_code[2:0];
      mem_addr_out <= dec_addr;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      opnd <= RST_REG;
    end else if (state == ST_IDLE && go && dec_ok) begin
      opnd <= gpr[dec_code[2:0]];
    end else if (state == ST_RUN && mc == rd_cycle(mode) && ts == 3'h2) begin
      opnd <= mem_rdata_in;
    end
  end

  // Read strobe in first T of read cycle, data one clock later
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mem_rd_out <= 1'b0;
      mem_wr_out <= 1'b0;
      mem_wdata_out <= 8'h00;
    end else begin
      mem_rd_out <= (state == ST_RUN) && (next_mc == rd_cycle(mode)) && (next_ts == 3'h1);
      mem_wr_out <= (state == ST_RUN) && (next_mc == wr_cycle(mode)) && (next_ts == 3'h1);
      if ((state == ST_RUN) && (next_mc == wr_cycle(mode)) && (next_ts == 3'h1)) begin
        mem_wdata_out <= alu_result;
      end
    end
  end

  // Error sets win over a software clear in the same cycle
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      err <= 1'b0;
    end else if (state == ST_IDLE && go && !dec_ok) begin
      err <= 1'b1;
    end else if (state == ST_IDLE && go) begin
      err <= 1'b0;
    end else if (wr_ok && wr_addr == OFF_STATUS && wr_strb[0] && wr_data[STAT_ERR]) begin
      err <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      instr <= RST_INSTR;
      idx1 <= RST_IDX;
      idx2 <= RST_IDX;
    end else if (wr_ok) begin
      for (int b = 0; b < 4; b++) begin
        if (wr_strb[b] && wr_addr == OFF_INSTR) begin
          instr[b*8 +: 8] <= wr_data[b*8 +: 8];
        end
      end
      for (int b = 0; b < 2; b++) begin
        if (wr_strb[b] && wr_addr == OFF_IDX1) begin
          idx1[b*8 +: 8] <= wr_data[b*8 +: 8];
        end
        if (wr_strb[b] && wr_addr == OFF_IDX2) begin
          idx2[b*8 +: 8] <= wr_data[b*8 +: 8];
        end
      end
    end
  end

  // Register file: software loads only while idle, results land at commit
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < 8; i++) begin
        gpr[i] <= RST_REG;
      end
    end else if (commit) begin
      gpr[SEL_MEM] <= alu_flags;
      if (mode == MD_REG) begin
        gpr[sel] <= alu_result;
      end
      if (mode == MD_DRL) begin
        gpr[SEL_A] <= alu_acc;
      end
    end else if (wr_ok) begin
      for (int p = 0; p < 4; p++) begin
        if (wr_addr == OFF_BC + 8'(p * 4)) begin
          // Accumulator sits above the flags in its pair, unlike the file slots
          if (wr_strb[1]) begin
            gpr[(p == 3) ? SEL_A : 3'(p * 2)] <= wr_data[15:8];
          end
          if (wr_strb[0]) begin
            gpr[(p == 3) ? SEL_MEM : 3'(p * 2 + 1)] <= wr_data[7:0];
          end
        end
      end
    end
  end
endmodule // sdr_unit

/* verification/sdr_unit_sva.sv */
// Port checker for the shift and digit rotate unit
`timescale 1ns/1ps
module sdr_unit_chk import sdr_pkg::*; (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [15:0] mem_addr_out,
  input wire logic mem_rd_out,
  input wire logic mem_wr_out,
  input wire logic [7:0] mem_wdata_out,
  input wire logic busy_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);
  a_busy_min_len: assert property ($rose(busy_out) |-> busy_out[*8])
    else $error("busy shorter than 8 clocks");
  a_busy_max_len: assert property ($rose(busy_out) |-> ##[8:23] !busy_out)
    else $error("busy longer than 23 clocks");
  a_no_early_read: assert property ($rose(busy_out) |-> !mem_rd_out[*8])
    else $error("memory read before third machine cycle");
  a_read_pulse: assert property (mem_rd_out |=> !mem_rd_out)
    else $error("read strobe longer than one clock");
  a_read_then_write: assert property (mem_rd_out |-> ##[4:7] mem_wr_out)
    else $error("no write back after read");
  a_addr_held: assert property (busy_out && $past(busy_out) |-> $stable(mem_addr_out))
    else $error("operand address moved mid instruction");
  a_mem_in_busy: assert property (mem_rd_out || mem_wr_out |-> busy_out)
    else $error("memory access while idle");
  a_wdata_held: assert property (mem_wr_out |=> $stable(mem_wdata_out))
    else $error("write data not held");
endmodule // sdr_unit_chk
bind sdr_unit sdr_unit_chk i_chk (.mclk_in(mclk_in), .nrst_in(nrst_in), .mem_addr_out(mem_addr_out),
  .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out), .mem_wdata_out(mem_wdata_out), .busy_out(busy_out));

/* verification/sdr_mem.sv */
// Byte memory on the far side of the operand bus
`timescale 1ns/1ps
module sdr_mem (
  input wire logic mclk_in,
  input wire logic [15:0] addr_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem [0:65535];
  initial rdata_out = 8'h00;
  // Data valid one clock only; scrambled after so late sampling shows
  always @(posedge mclk_in) begin
    rdata_out <= rd_in ? mem[addr_in] : ~rdata_out;
    if (wr_in) begin
      mem[addr_in] <= wdata_in;
    end
  end
endmodule // sdr_mem

/* verification/sdr_unit_tb.sv */
// Self-checking bench for the shift and digit rotate unit
`timescale 1ns/1ps
module sdr_unit_tb import sdr_pkg::*;;
  logic clk = 0, nrst = 0, awv = 0, wv = 0, arv = 0;
  logic [7:0] awa = 0, ara = 0, rv [0:7], fl, mrd;
  logic [31:0] wd = 0;
  logic [15:0] ix, iy;
  wire logic awr, wrd, bv, arr, rvl, mr, mw, busy;
  wire logic [1:0] br, rr;
  wire logic [31:0] rd;
  wire logic [15:0] ma;
  wire logic [7:0] mwd;
  int n_errors = 0, checks = 0, nb = 0, cyc = 0;
  logic [4:0] grp [0:2] = '{GRP_SLA, GRP_SRA, GRP_SRL};
  always #12.5 clk = ~clk;
  sdr_unit i_sdr_unit (.mclk_in(clk), .nrst_in(nrst), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wrd), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(1'b1),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rd),
    .s_axi_rresp_out(rr), .s_axi_rvalid_out(rvl), .s_axi_rready_in(1'b1), .mem_addr_out(ma),
    .mem_rd_out(mr), .mem_wr_out(mw), .mem_wdata_out(mwd), .mem_rdata_in(mrd), .busy_out(busy));
  sdr_mem i_sdr_mem (.mclk_in(clk), .addr_in(ma), .rd_in(mr), .wr_in(mw), .wdata_in(mwd), .rdata_out(mrd));
  task automatic summarize();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Hang guard: whole run needs far fewer clocks
  always @(posedge clk) begin
    cyc++;
    if (busy) nb <= nb + 1;
    if (cyc == 30000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv);
    chk(br, er);
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    ara <= a;
    arv <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rvl);
    d = rd;
    chk(rr, er);
  endtask
  // Fixed corners in B and C: shifts that empty the byte
  task automatic ld();
    foreach (rv[i]) rv[i] = $urandom;
    rv[0] = 8'h80;
    rv[1] = 8'h01;
    fl = $urandom;
    ix = $urandom;
    iy = $urandom;
    wr(OFF_BC, {16'h0000, rv[0], rv[1]}, RESP_OKAY);
    wr(OFF_DE, {16'h0000, rv[2], rv[3]}, RESP_OKAY);
    wr(OFF_HL, {16'h0000, rv[4], rv[5]}, RESP_OKAY);
    wr(OFF_AF, {16'h0000, rv[7], fl}, RESP_OKAY);
    wr(OFF_IDX1, {16'h0000, ix}, RESP_OKAY);
    wr(OFF_IDX2, {16'h0000, iy}, RESP_OKAY);
  endtask
  task automatic vf();
    logic [31:0] d;
    rdr(OFF_BC, d, RESP_OKAY);
    chk(d, {16'h0000, rv[0], rv[1]});
    rdr(OFF_DE, d, RESP_OKAY);
    chk(d, {16'h0000, rv[2], rv[3]});
    rdr(OFF_HL, d, RESP_OKAY);
    chk(d, {16'h0000, rv[4], rv[5]});
    rdr(OFF_AF, d, RESP_OKAY);
    chk(d, {16'h0000, rv[7], fl});
  endtask
  task automatic go(input logic [31:0] ins, input logic [4:0] ts, input logic [2:0] mc);
    logic [31:0] d;
    wr(OFF_INSTR, ins, RESP_OKAY);
    nb = 0;
    wr(OFF_CTRL, 32'h0000_0001, RESP_OKAY);
    wr(OFF_BC, 32'h0000_0000, RESP_SLVERR);
    while (busy && nb < 40) @(posedge clk);
    chk(nb, ts);
    rdr(OFF_STATUS, d, RESP_OKAY);
    chk({d[20:16], d[10:8]}, {ts, mc});
  endtask
  function automatic logic [15:0] shf(input int op, input logic [7:0] v, input logic [7:0] f);
    logic [7:0] r;
    r = op == 0 ? {v[6:0], 1'b0} : op == 1 ? {v[7], v[7:1]} : {1'b0, v[7:1]};
    return {r, r[7], r == 8'h00, f[5], 1'b0, f[3], ~^r, 1'b0, op == 0 ? v[7] : v[0]};
  endfunction
  initial begin
    logic [31:0] d;
    logic [15:0] ad, e;
    logic [7:0] m, dsp, code;
    void'($urandom(32'hE7CB));
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rdr(8'h40, d, RESP_DECERR);
    for (int op = 0; op < 3; op++) begin
      for (int s = 0; s < 10; s++) begin
        ld();
        m = $urandom;
        dsp = $urandom;
        code = {grp[op], s > 7 ? SEL_MEM : s[2:0]};
        ad = (s == 8 ? ix : s == 9 ? iy : {rv[4], rv[5]}) + {{8{dsp[7]}}, dsp};
        if (s == 6) ad = {rv[4], rv[5]};
        i_sdr_mem.mem[ad] = m;
        e = shf(op, s == 6 || s > 7 ? m : rv[s], fl);
        if (s > 7) go({code, dsp, PFX_CB, s == 8 ? PFX_IDX1 : PFX_IDX2}, 5'd23, MC_IDX);
        else go({16'h0000, code, PFX_CB}, s == 6 ? 5'd15 : 5'd8, s == 6 ? MC_PTR : MC_REG);
        if (s == 6 || s > 7) chk(i_sdr_mem.mem[ad], e[15:8]);
        else rv[s] = e[15:8];
        fl = e[7:0];
        vf();
      end
    end
    for (int k = 0; k < 2; k++) begin
      ld();
      m = $urandom;
      ad = {rv[4], rv[5]};
      i_sdr_mem.mem[ad] = m;
      go({16'h0000, OP_DIGIT_LEFT, PFX_ED}, 5'd18, MC_DRL);
      chk(i_sdr_mem.mem[ad], {m[3:0], rv[7][3:0]});
      rv[7] = {rv[7][7:4], m[7:4]};
      fl = {rv[7][7], rv[7] == 8'h00, fl[5], 1'b0, fl[3], ~^rv[7], 1'b0, fl[0]};
      vf();
    end
    wr(OFF_INSTR, {GRP_SRA, 3'h0, 8'h05, PFX_CB, PFX_IDX1}, RESP_OKAY);
    wr(OFF_CTRL, 32'h0000_0001, RESP_OKAY);
    rdr(OFF_STATUS, d, RESP_OKAY);
    chk(d[1:0], 2'h2);
    summarize();
  end
endmodule // sdr_unit_tb
